// File: ovfm_monitor.sv
`timescale 1ns/100ps
`include "ovfm_defines.svh"
module ovfm_monitor
  import ovfm_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  input  wire ovfm_acc_t   I_WR,
  input  wire ovfm_acc_t   I_RD,
  input  wire ovfm_clr_t   I_CLR,
  input  wire logic        I_OUTPUT_CMD_ON,
  input  wire logic        I_UNIT_TICK,
  input  wire logic [15:0] I_VOUT,
  output logic [15:0]      O_RD_DATA,
  output logic             O_RD_VALID,
  output logic             O_OUTPUT_EN,
  output logic             O_OV_WARN,
  output logic             O_UV_WARN,
  output logic             O_UV_FAULT
);

  logic [15:0] ov_warn_reg;
  logic [15:0] uv_warn_reg;
  logic [15:0] uv_fault_reg;
  logic [7:0]  react_reg;
  ovfm_state_t state_reg;
  ovfm_state_t state_next;
  logic [2:0]  tries_reg;
  logic [2:0]  tries_next;
  logic        cmd_on_reg;
  logic        uv_cond;
  logic        cmd_rise;
  logic        clear_evt;
  logic        timer_run;
  logic        timer_done;
  ovfm_resp_t  resp;
  logic [2:0]  retry_set;
  logic        exhausted;

  assign resp      = ovfm_resp_t'(react_reg[`OVFM_RESP_HI:`OVFM_RESP_LO]);
  assign retry_set = react_reg[`OVFM_RETRY_HI:`OVFM_RETRY_LO];
  assign uv_cond   = I_VOUT < uv_fault_reg;
  assign cmd_rise  = I_OUTPUT_CMD_ON && !cmd_on_reg;
  assign clear_evt = I_CLR.status_bit || I_CLR.clear_faults || cmd_rise;
  assign timer_run = (state_reg == ST_DEGLITCH) ||
                     (state_reg == ST_OFF_WAIT) ||
                     (state_reg == ST_RESTART);
  assign exhausted = (retry_set != `OVFM_RETRY_ENDLESS) &&
                     (tries_reg >= retry_set);

  // Threshold and reaction registers, written by command code
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ov_warn_reg  <= `OVFM_RST_OV_WARN;
      uv_warn_reg  <= `OVFM_RST_UV_WARN;
      uv_fault_reg <= `OVFM_RST_UV_FAULT;
      react_reg    <= `OVFM_RST_UV_REACT;
    end else if (I_WR.stb) begin
      case (I_WR.code)
        `OVFM_CODE_OV_WARN:  ov_warn_reg  <= I_WR.data;
        `OVFM_CODE_UV_WARN:  uv_warn_reg  <= I_WR.data;
        `OVFM_CODE_UV_FAULT: uv_fault_reg <= I_WR.data;
        `OVFM_CODE_UV_REACT: react_reg    <= I_WR.data[7:0];
        default:             ;
      endcase
    end
  end

  // Read port; unknown codes answer zero
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_RD_DATA  <= 16'h0000;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD.stb;
      if (I_RD.stb) begin
        case (I_RD.code)
          `OVFM_CODE_OV_WARN:  O_RD_DATA <= ov_warn_reg;
          `OVFM_CODE_UV_WARN:  O_RD_DATA <= uv_warn_reg;
          `OVFM_CODE_UV_FAULT: O_RD_DATA <= uv_fault_reg;
          `OVFM_CODE_UV_REACT: O_RD_DATA <= {8'h00, react_reg};
          default:             O_RD_DATA <= 16'h0000;
        endcase
      end
    end
  end

  // Pin level samples; warnings follow the voltage, not latched
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_OV_WARN  <= 1'b0;
      O_UV_WARN  <= 1'b0;
      cmd_on_reg <= 1'b0;
    end else begin
      O_OV_WARN  <= I_VOUT > ov_warn_reg;
      O_UV_WARN  <= I_VOUT < uv_warn_reg;
      cmd_on_reg <= I_OUTPUT_CMD_ON;
    end
  end

  // Sticky fault status; a new fault wins over a clear
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_UV_FAULT <= 1'b0;
    end else if (uv_cond) begin
      O_UV_FAULT <= 1'b1;
    end else if (clear_evt) begin
      O_UV_FAULT <= 1'b0;
    end
  end

  ovfm_delay_timer u_delay (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_run     (timer_run),
    .i_tick    (I_UNIT_TICK),
    .i_exp     (react_reg[`OVFM_DELAY_HI:`OVFM_DELAY_LO]),
    .o_done    (timer_done)
  );

  // Reaction sequencer
  always_comb begin
    state_next = state_reg;
    tries_next = tries_reg;
    if (!I_OUTPUT_CMD_ON) begin
      // Commanded off ends any retry sequence
      state_next = ST_RUN;
      tries_next = 3'h0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (uv_cond) begin
            case (resp)
              OVFM_RESP_IGNORE:   state_next = ST_RUN;
              OVFM_RESP_DEGLITCH: state_next = ST_DEGLITCH;
              OVFM_RESP_DISABLE:  state_next =
                (retry_set == `OVFM_RETRY_NEVER) ?
                ST_LATCHED : ST_OFF_WAIT;
              default:            state_next = ST_HOLD_OFF;
            endcase
          end
        end
        ST_DEGLITCH: begin
          if (!uv_cond) begin
            state_next = ST_RUN;
          end else if (timer_done) begin
            state_next = (retry_set == `OVFM_RETRY_NEVER) ?
                         ST_LATCHED : ST_OFF_WAIT;
          end
        end
        ST_OFF_WAIT: begin
          if (timer_done) begin
            state_next = ST_RESTART;
            if (retry_set != `OVFM_RETRY_ENDLESS) begin
              tries_next = 3'(tries_reg + 3'h1);
            end
          end
        end
        ST_RESTART: begin
          if (timer_done) begin
            if (!uv_cond) begin
              state_next = ST_RUN;
              tries_next = 3'h0;
            end else if (exhausted) begin
              state_next = ST_LATCHED;
            end else begin
              state_next = ST_OFF_WAIT;
            end
          end
        end
        ST_HOLD_OFF: begin
          if (!uv_cond) begin
            state_next = ST_RUN;
          end
        end
        ST_LATCHED: begin
          if (clear_evt) begin
            state_next = ST_RUN;
            tries_next = 3'h0;
          end
        end
        default: begin
          state_next = ST_RUN;
          tries_next = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_reg <= ST_RUN;
      tries_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      tries_reg <= tries_next;
    end
  end

  // Output enable from the next state so it acts in the same edge
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_OUTPUT_EN <= 1'b0;
    end else begin
      O_OUTPUT_EN <= I_OUTPUT_CMD_ON &&
                     ((state_next == ST_RUN) ||
                      (state_next == ST_DEGLITCH) ||
                      (state_next == ST_RESTART));
    end
  end

  property p_ov_warn;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      I_VOUT > ov_warn_reg |=> O_OV_WARN;
  endproperty
  a_ov_warn: assert property (p_ov_warn)
    else $error("Overvoltage warning missed");
  property p_uv_warn;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      I_VOUT >= uv_warn_reg |=> !O_UV_WARN;
  endproperty
  a_uv_warn: assert property (p_uv_warn)
    else $error("Undervoltage warning without cause");
  property p_fault_sticky;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      uv_cond |=> O_UV_FAULT ##1 (O_UV_FAULT || $past(clear_evt));
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("Fault status not held");
  property p_ignore;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_RUN && resp == OVFM_RESP_IGNORE && uv_cond &&
      I_OUTPUT_CMD_ON |=> O_OUTPUT_EN && state_reg == ST_RUN;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Ignored fault interrupted output");
  property p_deglitch;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_RUN && resp == OVFM_RESP_DEGLITCH && uv_cond &&
      I_OUTPUT_CMD_ON |=> state_reg == ST_DEGLITCH && O_OUTPUT_EN;
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("Delayed reaction did not keep running");
  property p_disable;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_RUN && resp == OVFM_RESP_DISABLE && uv_cond &&
      I_OUTPUT_CMD_ON |=> !O_OUTPUT_EN;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Output not disabled at once");
  property p_hold;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_HOLD_OFF && I_OUTPUT_CMD_ON && !uv_cond
      |=> state_reg == ST_RUN && O_OUTPUT_EN;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Output not resumed after fault went");
  property p_clear;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_LATCHED && clear_evt && I_OUTPUT_CMD_ON
      |=> state_reg == ST_RUN;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Latched fault not cleared");
  property p_never;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_RUN && resp == OVFM_RESP_DISABLE && uv_cond &&
      I_OUTPUT_CMD_ON && retry_set == `OVFM_RETRY_NEVER
      |=> state_reg == ST_LATCHED;
  endproperty
  a_never: assert property (p_never)
    else $error("Restart tried with retries off");
  property p_latched_off;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      state_reg == ST_LATCHED && !clear_evt |=> !O_OUTPUT_EN;
  endproperty
  a_latched_off: assert property (p_latched_off)
    else $error("Output on while latched off");

endmodule : ovfm_monitor

// File: ovfm_defines.svh
`ifndef OVFM_DEFINES_SVH
`define OVFM_DEFINES_SVH

// Command codes of the threshold and reaction registers
`define OVFM_CODE_OV_WARN    8'h42
`define OVFM_CODE_UV_WARN    8'h43
`define OVFM_CODE_UV_FAULT   8'h44
`define OVFM_CODE_UV_REACT   8'h45

// Reaction byte field positions
`define OVFM_RESP_HI         7
`define OVFM_RESP_LO         6
`define OVFM_RETRY_HI        5
`define OVFM_RETRY_LO        3
`define OVFM_DELAY_HI        2
`define OVFM_DELAY_LO        0

// Retry field codes
`define OVFM_RETRY_NEVER     3'h0
`define OVFM_RETRY_ENDLESS   3'h7

// Reset values
`define OVFM_RST_OV_WARN     16'hffff
`define OVFM_RST_UV_WARN     16'h0000
`define OVFM_RST_UV_FAULT    16'h0000
`define OVFM_RST_UV_REACT    8'h00

`endif

// File: ovfm_pkg.sv
package ovfm_pkg;

  typedef enum logic [1:0] {
    OVFM_RESP_IGNORE,
    OVFM_RESP_DEGLITCH,
    OVFM_RESP_DISABLE,
    OVFM_RESP_HOLD
  } ovfm_resp_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DEGLITCH,
    ST_OFF_WAIT,
    ST_RESTART,
    ST_HOLD_OFF,
    ST_LATCHED
  } ovfm_state_t;

  // One register access from the command decoder
  typedef struct packed {
    logic        stb;
    logic [7:0]  code;
    logic [15:0] data;
  } ovfm_acc_t;

  // Fault clear sources
  typedef struct packed {
    logic status_bit;
    logic clear_faults;
  } ovfm_clr_t;

endpackage : ovfm_pkg

// File: ovfm_delay_timer.sv
`timescale 1ns/100ps
`include "ovfm_defines.svh"
module ovfm_delay_timer
  import ovfm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic [2:0] i_exp,
  output logic            o_done
);

  logic [6:0] count_reg;
  logic [6:0] last_w;

  // Two to the power of the field, minus one
  assign last_w = 7'(({7'h00, 1'b1} << i_exp) - 8'h01);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_run) begin
      count_reg <= 7'h00;
      o_done    <= 1'b0;
    end else if (i_tick) begin
      // Greater-or-equal, so a field shrunk mid-count cannot run away
      if (count_reg >= last_w) begin
        count_reg <= 7'h00;
        o_done    <= 1'b1;
      end else begin
        count_reg <= 7'(count_reg + 7'h01);
        o_done    <= 1'b0;
      end
    end else begin
      o_done <= 1'b0;
    end
  end

  property p_done_after_tick;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_done |-> $past(i_tick) && $past(i_run);
  endproperty
  a_done_after_tick: assert property (p_done_after_tick)
    else $error("Delay done without a unit tick");

  property p_count_bound;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_run && count_reg <= last_w |=>
        !$stable(i_exp) || count_reg <= last_w;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("Delay count beyond two to the field");

endmodule : ovfm_delay_timer

// File: ovfm_host_model.sv
`timescale 1ns/100ps
module ovfm_host_model
  import ovfm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output ovfm_acc_t        o_wr,
  output ovfm_acc_t        o_rd,
  output ovfm_clr_t        o_clr
);
  initial begin
    o_wr  = '0;
    o_rd  = '0;
    o_clr = '0;
  end
  // Released fields inverted so a stale value never looks held
  task automatic write(input logic [7:0] c, input logic [15:0] d);
    o_wr = '{1'b1, c, d};
    @(posedge i_clk);
    #2;
    o_wr = '{1'b0, ~c, ~d};
    @(posedge i_clk);
    #2;
  endtask : write
  task automatic read(input logic [7:0] c, output logic [15:0] d);
    int n;
    o_rd = '{1'b1, c, 16'h0000};
    @(posedge i_clk);
    #2;
    o_rd = '{1'b0, ~c, 16'hffff};
    n = 0;
    while (!i_rd_valid && n < 3) begin
      @(posedge i_clk);
      #2;
      n++;
    end
    d = i_rd_valid ? i_rd_data : 16'hxxxx;
    // Idle edge so a following read never restrobes in this step
    @(posedge i_clk);
    #2;
  endtask : read
  // One pulse of either clear source
  task automatic clear(input logic by_bit);
    o_clr = '{by_bit, !by_bit};
    @(posedge i_clk);
    #2;
    o_clr = '0;
  endtask : clear
endmodule : ovfm_host_model

// File: tb_output_voltage_fault_monitor.sv
`timescale 1ns/100ps
module tb_output_voltage_fault_monitor
  import ovfm_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        cmd_on;
  logic        tick;
  logic [15:0] vout;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        en;
  logic        ov_warn;
  logic        uv_warn;
  logic        uv_fault;
  ovfm_acc_t   wr;
  ovfm_acc_t   rd;
  ovfm_clr_t   clr;
  int          errors;
  int          comparisons;
  int          cycles;
  int          n;
  logic [31:0] seed;
  logic [15:0] d;
  logic [15:0] lim [4];

  ovfm_monitor i_dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_WR(wr), .I_RD(rd), .I_CLR(clr),
    .I_OUTPUT_CMD_ON(cmd_on), .I_UNIT_TICK(tick), .I_VOUT(vout),
    .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_OUTPUT_EN(en),
    .O_OV_WARN(ov_warn), .O_UV_WARN(uv_warn), .O_UV_FAULT(uv_fault));
  ovfm_host_model i_host (
    .i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_wr(wr), .o_rd(rd), .o_clr(clr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [1:0] warn_exp(input logic [15:0] x, ov, uv);
    return {x > ov, x < uv};
  endfunction : warn_exp

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk1(input logic seen, input logic exp);
    check({15'h0, seen}, {15'h0, exp});
  endtask : chk1
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc
  // Delay unit pulses, spaced so each lands alone
  task automatic ticks(input int k);
    repeat (k) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(2);
    end
    cyc(2);
  endtask : ticks
  task automatic set_resp(input logic [1:0] r, input logic [2:0] t,
                          input logic [2:0] dl);
    i_host.write(8'h45, {8'h00, r, t, dl});
  endtask : set_resp

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    rst_n  = 1'b0;
    cmd_on = 1'b1;
    tick   = 1'b0;
    vout   = 16'h3000;
    seed   = 32'd88012;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    chk1(en, 1'b1);
    chk1(uv_fault, 1'b0);
    for (int k = 0; k < 5; k++) begin
      i_host.read(8'h42 + 8'(k), d);
      check(d, k == 0 ? 16'hffff : 16'h0000);
    end
    // Random limits and voltages
    repeat (4) begin
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        lim[k] = seed[15:0];
        i_host.write(8'h42 + 8'(k), lim[k]);
        i_host.read(8'h42 + 8'(k), d);
        check(d, k == 3 ? {8'h00, lim[k][7:0]} : lim[k]);
      end
      seed = lfsr(seed);
      vout = seed[31:16];
      cyc(3);
      check({14'h0, ov_warn, uv_warn},
            {14'h0, warn_exp(vout, lim[0], lim[1])});
    end
    cmd_on = 1'b0;
    vout   = 16'h3000;
    i_host.write(8'h42, 16'h4000);
    i_host.write(8'h43, 16'h2000);
    i_host.write(8'h44, 16'h1800);
    set_resp(2'b00, 3'h0, 3'h0);
    cmd_on = 1'b1;
    i_host.clear(1'b0);
    cyc(2);
    chk1(uv_fault, 1'b0);
    vout = 16'h1000;
    ticks(3);
    chk1(uv_fault, 1'b1);
    chk1(en, 1'b1);
    vout = 16'h3000;
    cyc(3);
    chk1(uv_fault, 1'b1);
    i_host.clear(1'b1);
    cyc(2);
    chk1(uv_fault, 1'b0);
    set_resp(2'b11, 3'h0, 3'h0);
    vout = 16'h1000;
    ticks(4);
    chk1(en, 1'b0);
    vout = 16'h3000;
    cyc(3);
    chk1(en, 1'b1);
    // Deglitch length is two to the delay field
    for (int dl = 0; dl < 4; dl++) begin
      set_resp(2'b01, 3'h0, 3'(dl));
      vout = 16'h1000;
      cyc(2);
      ticks((1 << dl) - 1);
      chk1(en, 1'b1);
      ticks(1);
      chk1(en, 1'b0);
      vout = 16'h3000;
      ticks(2);
      chk1(en, 1'b0);
      i_host.clear(dl[0]);
      cyc(2);
      chk1(en, 1'b1);
    end
    // Retry never, once, twice, and endless
    for (int r = 0; r < 4; r++) begin
      n = (r == 3) ? 3 : r;
      set_resp(2'b10, (r == 3) ? 3'h7 : 3'(r), 3'h0);
      vout = 16'h1000;
      cyc(3);
      chk1(en, 1'b0);
      repeat (n) begin
        ticks(1);
        chk1(en, 1'b1);
        ticks(1);
        chk1(en, 1'b0);
      end
      ticks(1);
      chk1(en, r == 3);
      cmd_on = 1'b0;
      cyc(2);
      chk1(en, 1'b0);
      vout   = 16'h3000;
      cmd_on = 1'b1;
      cyc(3);
      chk1(en, 1'b1);
      i_host.clear(1'b0);
    end
    // Reset in mid-run clears a latched fault as well
    set_resp(2'b10, 3'h0, 3'h0);
    vout = 16'h1000;
    cyc(3);
    chk1(en, 1'b0);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    chk1(en, 1'b1);
    chk1(uv_fault, 1'b0);
    report_and_stop();
  end
endmodule : tb_output_voltage_fault_monitor
